// ==== rtl/bank_decode.v ====
// Purpose: first-level bank split of one master's address
// Assumes: combinational, same clock domain as the caller
// Notes: one instance per master
`timescale 1ns/1ps
`default_nettype none
`include "boot_remap_defines.vh"
module bank_decode (
    // address in
    input wire [31:0] i_addr,
    // bank class out
    output wire o_is_int,
    output wire o_is_ext,
    output wire o_is_periph,
    output wire [7:0] o_ext_cs
);
    wire [3:0] bank;
    genvar c;

    // top nibble picks one of sixteen banks
    assign bank = i_addr[31:28];
    assign o_is_int = (bank == `BANK_INTERNAL);
    assign o_is_ext = (bank >= `BANK_EXT_FIRST) && (bank <= `BANK_EXT_LAST);
    assign o_is_periph = (bank == `BANK_PERIPH);

    // one chip select per external bank, each a full 256 MB area
    generate
        for (c = 0; c < 8; c = c + 1) begin : g_cs
            if (c < 7) begin : g_used
                // chip select c serves bank c+1
                localparam integer CS_BANK = c + 1;
                assign o_ext_cs[c] = o_is_ext && ({28'h0000000, bank} == CS_BANK);
            end else begin : g_spare
                assign o_ext_cs[c] = 1'b0; // no eighth external bank in the map
            end
        end
    endgenerate
endmodule // bank_decode
`default_nettype wire

// ==== rtl/boot_remap_address_decoder.v ====
// Purpose: per-master address decoder with boot select and remap
// Assumes: masters hold i_m_valid until o_m_ready; one decode per cycle each
// Notes: answers one cycle after acceptance; arbitration lives downstream
`timescale 1ns/1ps
`default_nettype none
`include "boot_remap_defines.vh"
module boot_remap_address_decoder #(
    parameter NUM_MASTERS = 6,
    parameter BOOT_MASTERS = 2
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // boot strap pin and remap control
    input wire i_boot_select_pin,
    input wire i_remap_set,
    input wire i_remap_clear,
    // master requests
    input wire [NUM_MASTERS-1:0] i_m_valid,
    input wire [NUM_MASTERS*32-1:0] i_m_addr,
    // master answers
    output wire [NUM_MASTERS-1:0] o_m_ready,
    output reg [NUM_MASTERS-1:0] o_m_resp_valid,
    output reg [NUM_MASTERS-1:0] o_m_abort,
    output reg [NUM_MASTERS*3-1:0] o_m_slave,
    output reg [NUM_MASTERS*32-1:0] o_m_offset,
    output reg [NUM_MASTERS*8-1:0] o_m_ext_cs_n,
    // status and static memory boot defaults
    output wire o_remap_active,
    output wire o_boot_from_rom,
    output reg o_smc_byte_select,
    output reg o_smc_bus_16bit,
    output reg o_smc_rw_by_cs
);
    // ****************************************
    // boot state
    // ****************************************
    reg remap_reg;
    wire boot_rom;
    wire boot_ready;

    boot_select_latch u_boot (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_boot_select_pin(i_boot_select_pin),
        .o_boot_from_rom(boot_rom),
        .o_boot_ready(boot_ready)
    );

    // remap flag; a set arriving with a clear wins so a late set is not lost
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remap_reg <= `REMAP_RESET;
        end else if (i_remap_set) begin
            remap_reg <= 1'b1;
        end else if (i_remap_clear) begin
            remap_reg <= 1'b0;
        end
    end

    assign o_remap_active = remap_reg;
    assign o_boot_from_rom = boot_rom;

    // no request is taken until the strap is caught, so the first fetch sees the boot map
    assign o_m_ready = {NUM_MASTERS{boot_ready}};

    // static memory defaults while external chip select zero is the boot memory
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_smc_byte_select <= 1'b0;
            o_smc_bus_16bit <= 1'b0;
            o_smc_rw_by_cs <= 1'b0;
        end else if (boot_ready && !boot_rom) begin
            o_smc_byte_select <= `SMC_BOOT_BYTE_SELECT;
            o_smc_bus_16bit <= `SMC_BOOT_BUS_16BIT;
            o_smc_rw_by_cs <= `SMC_BOOT_RW_BY_CS;
        end
    end

    // ****************************************
    // per-master decoders
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_MASTERS; g = g + 1) begin : g_master
            wire [31:0] addr;
            wire is_int;
            wire is_ext;
            wire is_per;
            wire [7:0] cs_oh;
            wire [7:0] region;
            reg [2:0] sel_next;
            reg [7:0] cs_next;
            reg [31:0] off_next;
            reg abort_next;

            assign addr = i_m_addr[g*32 +: 32];
            assign region = addr[27:20];

            bank_decode u_bank (
                .i_addr(addr),
                .o_is_int(is_int),
                .o_is_ext(is_ext),
                .o_is_periph(is_per),
                .o_ext_cs(cs_oh)
            );

            // second level: region and boot choice
            always @* begin
                sel_next = `SLV_NONE;
                cs_next = 8'h00;
                off_next = {4'h0, addr[27:0]};
                abort_next = 1'b0;
                if (is_ext) begin
                    sel_next = `SLV_EXT;
                    cs_next = cs_oh;
                end else if (is_per) begin
                    // top 16 KB belongs to the system controller
                    if (addr[31:14] == `SYSC_ADDR_HI) begin
                        sel_next = `SLV_SYSC;
                    end else begin
                        sel_next = `SLV_PERIPH;
                    end
                end else if (is_int) begin
                    off_next = {12'h000, addr[19:0]};
                    case (region)
                        `REGION_BOOT: begin
                            // only the first 1 MB follows remap and strap
                            if (g >= BOOT_MASTERS) begin
                                abort_next = 1'b1;
                            end else if (remap_reg) begin
                                sel_next = `SLV_FIRST_INTERNAL_SRAM;
                            end else if (boot_rom) begin
                                sel_next = `SLV_ROM;
                            end else begin
                                sel_next = `SLV_EXT;
                                cs_next = `CS0_ONEHOT;
                            end
                        end
                        `REGION_ROM: sel_next = `SLV_ROM;
                        `REGION_FIRST_INTERNAL_SRAM: sel_next = `SLV_FIRST_INTERNAL_SRAM;
                        `REGION_SECOND_INTERNAL_SRAM: sel_next = `SLV_SECOND_INTERNAL_SRAM;
                        `REGION_USBH: sel_next = `SLV_USBH;
                        default: abort_next = 1'b1;
                    endcase
                end else begin
                    abort_next = 1'b1;
                end
            end

            // answer register: one-cycle response pulse, routing held until next request
            always @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_m_resp_valid[g] <= 1'b0;
                    o_m_abort[g] <= 1'b0;
                    o_m_slave[g*3 +: 3] <= `SLV_NONE;
                    o_m_offset[g*32 +: 32] <= 32'h00000000;
                    o_m_ext_cs_n[g*8 +: 8] <= `CS_N_RESET;
                end else begin
                    o_m_resp_valid[g] <= i_m_valid[g] && boot_ready;
                    o_m_abort[g] <= i_m_valid[g] && boot_ready && abort_next;
                    if (i_m_valid[g] && boot_ready) begin
                        o_m_slave[g*3 +: 3] <= sel_next;
                        o_m_offset[g*32 +: 32] <= off_next;
                        o_m_ext_cs_n[g*8 +: 8] <= ~cs_next;
                    end
                end
            end
        end
    endgenerate
endmodule // boot_remap_address_decoder
`default_nettype wire

// ==== rtl/boot_remap_defines.vh ====
// Purpose: constants for the per-master boot/remap address decoder
// Assumes: 32-bit byte addresses, 256 MB banks, 1 MB internal regions
// Notes: definitions only, no logic
//
// Functional notes
// - split 32-bit space into sixteen 256 MB banks by address bits 31:28
// - banks one to seven go to the external bus, one chip select each
// - bank zero is internal memory, decoded again into 1 MB regions
// - bank fifteen goes through the bridge to the peripheral bus
// - accesses to unassigned areas complete with an abort response
// - every master has its own decoder, same map except masters from BOOT_MASTERS up abort in the first 1 MB
// - processor masters see boot memory, external boot or remapped SRAM at zero
// - remap set puts the first internal SRAM at zero, ignoring the pin
// - remap clear and pin high puts the internal ROM at zero
// - remap clear and pin low puts external chip select zero at zero
// - boot-select pin is caught on the third edge after reset release and holds until next reset
// - boot mapping covers only 0x00000000 to 0x000fffff
// - ROM, first SRAM, second SRAM always at 1, 2 and 3 MB
// - USB host registers always decode at 0x00500000
// - boot mapping is in effect before the first fetch after reset
// - external chip selects zero to six each own one 256 MB area; chip select seven is never driven active
// - external boot defaults static path to byte select, 16-bit, chip-select strobes
// - system controller registers decode in the top 16 KB of the space
`ifndef BOOT_REMAP_DEFINES_VH
`define BOOT_REMAP_DEFINES_VH

// bank numbers (address bits 31:28)
`define BANK_INTERNAL 4'h0
`define BANK_EXT_FIRST 4'h1
`define BANK_EXT_LAST 4'h7
`define BANK_PERIPH 4'hf

// 1 MB regions inside bank zero (address bits 27:20)
`define REGION_BOOT 8'h00
`define REGION_ROM 8'h01
`define REGION_FIRST_INTERNAL_SRAM 8'h02
`define REGION_SECOND_INTERNAL_SRAM 8'h03
`define REGION_USBH 8'h05

// top 16 KB of the space, compared on address bits 31:14
`define SYSC_ADDR_HI 18'h3ffff

// slave codes presented with each decode answer
`define SLV_NONE 3'h0
`define SLV_ROM 3'h1
`define SLV_FIRST_INTERNAL_SRAM 3'h2
`define SLV_SECOND_INTERNAL_SRAM 3'h3
`define SLV_USBH 3'h4
`define SLV_EXT 3'h5
`define SLV_PERIPH 3'h6
`define SLV_SYSC 3'h7

// reset values and the one-hot chip select used for external boot
`define REMAP_RESET 1'b0
`define CS_N_RESET 8'hff
`define CS0_ONEHOT 8'h01

// edges after reset release spent filling the strap synchroniser before capture
`define BOOT_SYNC_FILL 2'h2

// static memory defaults applied when booting from external chip select zero
`define SMC_BOOT_BYTE_SELECT 1'b1
`define SMC_BOOT_BUS_16BIT 1'b1
`define SMC_BOOT_RW_BY_CS 1'b1

`endif

// ==== rtl/boot_select_latch.v ====
// Purpose: catch the boot-select pin once after reset release
// Assumes: pin is asynchronous to i_core_clk and steady around reset
// Notes: o_boot_ready rises on the third edge after release
`timescale 1ns/1ps
`default_nettype none
`include "boot_remap_defines.vh"
module boot_select_latch (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // pin
    input wire i_boot_select_pin,
    // caught value
    output reg o_boot_from_rom,
    output reg o_boot_ready
);
    reg sync1_reg;
    reg sync2_reg;
    reg [1:0] fill_reg;

    // two-flop synchroniser; the first stage feeds only the second
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= i_boot_select_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // wait until both sync stages hold the pin, else the reset value of the
    // second stage would be caught; then capture once and freeze until next reset
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fill_reg <= 2'h0;
            o_boot_from_rom <= 1'b0;
            o_boot_ready <= 1'b0;
        end else if (fill_reg != `BOOT_SYNC_FILL) begin
            fill_reg <= fill_reg + 2'h1;
        end else if (!o_boot_ready) begin
            o_boot_from_rom <= sync2_reg;
            o_boot_ready <= 1'b1;
        end
    end
endmodule // boot_select_latch
`default_nettype wire

// ==== test/boot_remap_address_decoder_test.sv ====
// Purpose: scenarios for the boot and remap decoder
// Assumes: default six masters, 0 and 1 are processor masters
// Notes: master 0 is also watched by the monitor
`timescale 1ns/1ps
`default_nettype none
module boot_remap_address_decoder_test;
    logic core_clk = 1'b0, rst_n = 1'b0, boot_pin = 1'b1, remap_set = 1'b0, remap_clear = 1'b0;
    logic [5:0] go = '0;
    logic [31:0] addr = '0;
    wire [5:0] valid, ready, resp, abort;
    wire [191:0] maddr, offset;
    wire [17:0] slave;
    wire [47:0] cs_n;
    wire remap_on, from_rom, smc_bs, smc_16, smc_cs;
    int fail_count = 0, check_count = 0;
    always #10 core_clk = ~core_clk;
    master_port_model i_master_port_model (.i_core_clk(core_clk), .i_go(go), .i_addr(addr),
        .i_ready(ready), .o_valid(valid), .o_addr(maddr));
    boot_remap_address_decoder i_boot_remap_address_decoder (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_boot_select_pin(boot_pin), .i_remap_set(remap_set), .i_remap_clear(remap_clear),
        .i_m_valid(valid), .i_m_addr(maddr), .o_m_ready(ready), .o_m_resp_valid(resp), .o_m_abort(abort),
        .o_m_slave(slave), .o_m_offset(offset), .o_m_ext_cs_n(cs_n), .o_remap_active(remap_on),
        .o_boot_from_rom(from_rom), .o_smc_byte_select(smc_bs), .o_smc_bus_16bit(smc_16), .o_smc_rw_by_cs(smc_cs));
    // ************
    // shared tasks
    // ************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic pin);
        @(posedge core_clk);
        rst_n <= 1'b0;
        boot_pin <= pin;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("ready", 32'h0, {26'h0, ready});
    endtask
    // one request; slave 0 means an abort is expected
    task automatic req(input int g, input logic [31:0] a, input logic [2:0] es, input logic [7:0] ecs = 8'hff);
        int n;
        @(posedge core_clk);
        go[g] <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        go[g] <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (resp[g] !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            finish_test();
        end else begin
            chk("abort", {31'h0, es == 3'h0}, {31'h0, abort[g]});
            chk("slave", {29'h0, es}, {29'h0, slave[g*3+:3]});
            chk("cs_n", {24'h0, ecs}, {24'h0, cs_n[g*8+:8]});
            if (es != 3'h0) chk("offset", a[31:28] == 4'h0 ? {12'h0, a[19:0]} : {4'h0, a[27:0]}, offset[g*32+:32]);
        end
    endtask
    // ***********
    // scenarios
    // ***********
    task automatic t_rom_boot;
        do_reset(1'b1);
        req(0, 32'h0000_0010, 3'h1);
        req(1, 32'h000f_fffc, 3'h1);
        req(0, 32'h0010_0000, 3'h1);
        req(1, 32'h0020_0004, 3'h2);
        req(0, 32'h0030_0008, 3'h3);
        req(0, 32'h0050_0000, 3'h4);
        req(0, 32'h0040_0000, 3'h0);
        req(2, 32'h0000_0000, 3'h0);
        req(3, 32'h0020_0000, 3'h2);
        chk("from_rom", 32'h1, {31'h0, from_rom});
        chk("smc", 32'h0, {29'h0, smc_bs, smc_16, smc_cs});
    endtask
    task automatic t_map;
        for (int k = 1; k < 15; k++) begin
            if (k < 8) req(k % 6, {k[3:0], 28'hffffffc}, 3'h5, ~(8'h01 << (k - 1)));
            else req(0, {k[3:0], 28'h0}, 3'h0);
        end
        req(1, 32'hf000_0000, 3'h6);
        req(0, 32'hffff_bffc, 3'h6);
        req(0, 32'hffff_c000, 3'h7);
        req(1, 32'hffff_ffff, 3'h7);
    endtask
    task automatic t_remap;
        @(posedge core_clk);
        remap_set <= 1'b1;
        boot_pin <= 1'b0;
        @(posedge core_clk);
        remap_set <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("remap", 32'h1, {31'h0, remap_on});
        req(0, 32'h0000_0100, 3'h2);
        req(1, 32'h0010_0000, 3'h1);
        @(posedge core_clk);
        remap_clear <= 1'b1;
        @(posedge core_clk);
        remap_clear <= 1'b0;
        req(0, 32'h0000_0000, 3'h1);
    endtask
    task automatic t_ext_boot;
        do_reset(1'b0);
        req(1, 32'h0000_0004, 3'h5, 8'hfe);
        chk("remap", 32'h0, {31'h0, remap_on});
        chk("from_rom", 32'h0, {31'h0, from_rom});
        chk("smc", 32'h7, {29'h0, smc_bs, smc_16, smc_cs});
        boot_pin <= 1'b1;
        req(0, 32'h0000_0000, 3'h5, 8'hfe);
    endtask
    initial begin
        t_rom_boot();
        t_map();
        t_remap();
        t_ext_boot();
        finish_test();
    end
endmodule // boot_remap_address_decoder_test
`default_nettype wire

// ==== test/boot_remap_monitor.sv ====
// Purpose: decode checks on master 0
// Assumes: master 0 is a processor master
// Notes: other masters are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module boot_remap_monitor #(
    parameter NUM_MASTERS = 6
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire [NUM_MASTERS-1:0] i_m_valid,
    input wire [NUM_MASTERS*32-1:0] i_m_addr,
    input wire [NUM_MASTERS-1:0] o_m_ready,
    input wire [NUM_MASTERS-1:0] o_m_resp_valid,
    input wire [NUM_MASTERS-1:0] o_m_abort,
    input wire [NUM_MASTERS*3-1:0] o_m_slave,
    input wire [NUM_MASTERS*8-1:0] o_m_ext_cs_n,
    input wire o_remap_active
);
    // ***********
    // decode map
    // ***********
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire [31:0] a0 = i_m_addr[31:0];
    wire [2:0] s0 = o_m_slave[2:0];
    sequence s_take; i_m_valid[0] && o_m_ready[0]; endsequence
    sequence s_ok; o_m_resp_valid[0] && !o_m_abort[0]; endsequence
    property p_resp; s_take |=> o_m_resp_valid[0]; endproperty
    a_resp: assert property (p_resp) else $error("no answer");
    property p_idle; !(i_m_valid[0] && o_m_ready[0]) |=> !o_m_resp_valid[0]; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_ext; s_take ##0 (a0[31:28] inside {[1:7]}) |=> s_ok ##0 s0 == 3'h5
        ##0 o_m_ext_cs_n[7:0] == ~(8'h01 << ($past(a0[31:28]) - 4'h1)); endproperty
    a_ext: assert property (p_ext) else $error("bad ext select");
    property p_unused; s_take ##0 (a0[31:28] inside {[8:14]}) |=> o_m_resp_valid[0] && o_m_abort[0]; endproperty
    a_unused: assert property (p_unused) else $error("no abort");
    property p_sysc; s_take ##0 a0[31:14] == 18'h3ffff |=> s_ok ##0 s0 == 3'h7; endproperty
    a_sysc: assert property (p_sysc) else $error("bad sysc");
    property p_periph; s_take ##0 a0[31:28] == 4'hf && a0[31:14] != 18'h3ffff |=> s_ok ##0 s0 == 3'h6; endproperty
    a_periph: assert property (p_periph) else $error("bad periph");
    property p_remap; s_take ##0 o_remap_active && a0[31:20] == 12'h0 |=> s_ok ##0 s0 == 3'h2; endproperty
    a_remap: assert property (p_remap) else $error("bad remap");
    property p_fixed; s_take ##0 a0[31:22] == 10'h0 && a0[21:20] != 2'h0
        |=> s_ok ##0 s0 == {1'b0, $past(a0[21:20])}; endproperty
    a_fixed: assert property (p_fixed) else $error("bad fixed area");
    property p_usb; s_take ##0 a0[31:20] == 12'h005 |=> s_ok ##0 s0 == 3'h4; endproperty
    a_usb: assert property (p_usb) else $error("bad usb host");
    property p_hold; !(i_m_valid[0] && o_m_ready[0]) |=> $stable(s0); endproperty
    a_hold: assert property (p_hold) else $error("slave moved");
endmodule // boot_remap_monitor
bind boot_remap_address_decoder boot_remap_monitor #(.NUM_MASTERS(NUM_MASTERS)) i_boot_remap_monitor (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_m_valid(i_m_valid), .i_m_addr(i_m_addr),
    .o_m_ready(o_m_ready), .o_m_resp_valid(o_m_resp_valid), .o_m_abort(o_m_abort),
    .o_m_slave(o_m_slave), .o_m_ext_cs_n(o_m_ext_cs_n), .o_remap_active(o_remap_active));
`default_nettype wire

// ==== test/master_port_model.sv ====
// Purpose: bus masters in front of the decoder
// Assumes: bench pulses i_go for one cycle per request
// Notes: holds each request until the decoder takes it
`timescale 1ns/1ps
`default_nettype none
module master_port_model #(
    parameter NUM_MASTERS = 6
) (
    input wire logic i_core_clk,
    input wire logic [NUM_MASTERS-1:0] i_go,
    input wire logic [31:0] i_addr,
    input wire logic [NUM_MASTERS-1:0] i_ready,
    output logic [NUM_MASTERS-1:0] o_valid = '0,
    output logic [NUM_MASTERS*32-1:0] o_addr = '0
);
    // ************
    // request hold
    // ************
    // released address lines show junk so a stale decode cannot pass
    always @(posedge i_core_clk) begin
        for (int g = 0; g < NUM_MASTERS; g++) begin
            if (i_go[g]) begin
                o_valid[g] <= 1'b1;
                o_addr[g*32+:32] <= i_addr;
            end else if (o_valid[g] && i_ready[g]) begin
                o_valid[g] <= 1'b0;
                o_addr[g*32+:32] <= ~o_addr[g*32+:32];
            end
        end
    end
endmodule // master_port_model
`default_nettype wire
